// ==== design/rlwg_pkg.sv ====
// Package for the RGB LED waveform generator: register map, fields, timing.
// Assumes a 40 MHz mclk and an AHB-Lite register bus with 32-bit data.
package rlwg_pkg;

  // Clock and base time unit, in picoseconds
  localparam int unsigned CLK_PERIOD_PS  = 25000;
  localparam int unsigned BASE_UNIT_PS   = 60280;
  localparam int          ACC_W          = 17;
  localparam logic [ACC_W-1:0] ACC_STEP  = ACC_W'(CLK_PERIOD_PS);
  localparam logic [ACC_W-1:0] ACC_LIMIT = ACC_W'(BASE_UNIT_PS);

  // Register indices; byte address is four times the index
  localparam logic [29:0] CTRL_IDX     = 30'h0000009a;
  localparam logic [29:0] TIMING_IDX   = 30'h0000009b;
  localparam logic [29:0] BUF_BASE_IDX = 30'h0000f200;
  localparam logic [29:0] BUF_LAST_IDX = 30'h0000f217;
  localparam int          BUF_BYTES    = 24;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [7:0]  TIMING_RESET = 8'h00;
  localparam logic [7:0]  BYTE_RESET   = 8'h00;

  // Timing figures in base units, gap codes in gap units, and bytes per LED
  localparam logic [4:0] PERIOD_BASE    = 5'h11;
  localparam logic [4:0] ONE_HIGH_BASE  = 5'h0a;
  localparam logic [4:0] ZERO_HIGH_BASE = 5'h04;
  localparam logic [4:0] BYTES_PER_LED  = 5'h03;
  localparam logic [5:0] GAP_CODE0      = 6'h07;
  localparam logic [5:0] GAP_CODE1      = 6'h0b;
  localparam logic [5:0] GAP_CODE2      = 6'h15;
  localparam logic [5:0] GAP_CODE3      = 6'h25;
  localparam int         GAP_SCALE_DEF  = 128;

  // Run modes
  localparam logic [1:0] MODE_ONE_GAP   = 2'h2;
  localparam logic [1:0] MODE_ONE_NOGAP = 2'h3;

  // AHB-Lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef struct packed {
    logic [1:0] resetGapSelect;
    logic [1:0] runModeSelect;
    logic [2:0] frameLengthSelect;
    logic       generatorEnable;
  } rlwg_ctrl_t;

  typedef struct packed {
    logic [2:0] bitPeriodSelect;
    logic [2:0] oneHighTimeSelect;
    logic [1:0] zeroHighTimeSelect;
  } rlwg_timing_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BITS,
    ST_GAP
  } rlwg_state_t;

endpackage

// ==== design/rlwg_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides and a flush.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/10ps
module rlwg_fifo
  import rlwg_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || WIDTH < 1) begin : gBadParams
    $error("rlwg_fifo: DEPTH must be at least 2 and WIDTH at least 1");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_reg;
  logic [PW-1:0]    rdPtr_reg;
  logic [PW:0]      count_reg;
  logic             doPush;
  logic             doPop;

  assign inReady  = (count_reg != (PW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData  = mem[rdPtr_reg];
  assign doPush   = inValid && inReady && !flush;
  assign doPop    = outValid && outReady && !flush;

  always_ff @(posedge mclk) begin
    if (doPush) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doPush) begin
        wrPtr_reg <= (wrPtr_reg == PW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (doPop) begin
        rdPtr_reg <= (rdPtr_reg == PW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (PW+1)'(doPush) - (PW+1)'(doPop);
    end
  end

endmodule

// ==== design/rlwg_top.sv ====
// RGB LED waveform generator: AHB-Lite registers, 24-byte buffer, serial encoder.
// Assumes mclk at 40 MHz, a single AHB-Lite master, and the pad outside
// resolving ledPinOut/ledPinOe into the LED data wire.
//
// Behaviour
// R1 - Shift 24-byte buffer out on one pin
// R2 - Zero bit: zero-high time, then low
// R3 - One bit: one-high time, then low
// R4 - Frames separated by low reset gap
// R5 - Frame length is 3 times (code+1) bytes
// R6 - Modes 00/01 repeat forever, enable kept
// R7 - Mode 10: frame, gap, clear enable
// R8 - Mode 11: frame only, clear enable
// R9 - Gap code picks 7/11/21/37 gap units
// R10 - Bit period is 17 plus code units
// R11 - One-high time is 10 plus code units
// R12 - Zero-high time is 4 plus code units
// R13 - Enable low gives pin to GPIO
// R14 - Software stops continuous mode by clearing enable
// R15 - Lowest byte first, MSB first, no gaps
// R16 - Both config registers reset to zero
`timescale 1ns/10ps
module rlwg_top
  import rlwg_pkg::*;
#(
  parameter int GAP_SCALE  = GAP_SCALE_DEF,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        ledPinIn,
  output logic             ledPinOut,
  output logic             ledPinOe,
  input  wire logic        gpioOutValue,
  input  wire logic        gpioOutEnable,
  output logic             gpioInValue
);

  // Gap length in base units must fit the 16-bit gap counter
  if (GAP_SCALE < 1 || int'(GAP_CODE3) * GAP_SCALE > 65535) begin : gBadGapScale
    $error("rlwg_top: GAP_SCALE out of range");
  end
  if (FIFO_DEPTH < 2) begin : gBadFifoDepth
    $error("rlwg_top: FIFO_DEPTH must be at least 2");
  end

  // Registers and buffer
  rlwg_ctrl_t   ctrl_reg;
  rlwg_timing_t timing_reg;
  logic [7:0]   txBuf [BUF_BYTES];

  // Bus state
  logic        dpWrite_reg;
  logic        rdPend_reg;
  logic [29:0] dpIdx_reg;
  logic [31:0] hrdata_reg;
  logic        takeXfer;
  logic [29:0] addrIdx;

  // Timing base
  logic [ACC_W-1:0] acc_reg;
  logic             tick_reg;

  // Sequencer
  rlwg_state_t state_reg;
  logic [4:0]  feedIdx_reg;
  logic [4:0]  feedLeft_reg;
  logic [4:0]  txLeft_reg;
  logic [7:0]  shift_reg;
  logic        byteValid_reg;
  logic [2:0]  bitIdx_reg;
  logic [4:0]  unitCnt_reg;
  logic [15:0] gapCnt_reg;
  logic        waveOut_reg;
  logic        pinOut_reg;
  logic        pinOe_reg;
  logic        pinSync1_reg;
  logic        pinSync2_reg;

  // Derived terms
  logic [4:0]  frameBytes;
  logic [4:0]  periodUnits;
  logic [4:0]  highUnits;
  logic [15:0] gapUnits;
  logic        bitEnd;
  logic        lastBitEnd;
  logic        frameEnd;
  logic        gapEnd;
  logic        startFrame;
  logic        hwClear;
  logic        pop;
  logic        fifoInValid;
  logic        fifoInReady;
  logic        fifoOutValid;
  logic [7:0]  fifoOutData;
  logic [15:0] gapCode;

  // Bus slave
  assign addrIdx  = haddr[31:2];
  assign takeXfer = hsel && (htrans == HTRANS_NONSEQ) && hready;
  assign hresp    = HRESP_OKAY;
  // Reads take one wait state so a write just before is already visible
  assign hreadyout = !rdPend_reg;
  assign hrdata    = hrdata_reg;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dpWrite_reg <= 1'b0;
      rdPend_reg  <= 1'b0;
      dpIdx_reg   <= '0;
    end else begin
      dpWrite_reg <= takeXfer && hwrite;
      rdPend_reg  <= takeXfer && !hwrite;
      if (takeXfer) begin
        dpIdx_reg <= addrIdx;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hrdata_reg <= '0;
    end else if (rdPend_reg) begin
      if (dpIdx_reg == CTRL_IDX) begin
        hrdata_reg <= {24'h000000, ctrl_reg};
      end else if (dpIdx_reg == TIMING_IDX) begin
        hrdata_reg <= {24'h000000, timing_reg};
      end else if (dpIdx_reg >= BUF_BASE_IDX && dpIdx_reg <= BUF_LAST_IDX) begin
        hrdata_reg <= {24'h000000, txBuf[5'(dpIdx_reg - BUF_BASE_IDX)]};
      end else begin
        hrdata_reg <= '0;
      end
    end
  end

  // Control register; a software write wins over the hardware clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= rlwg_ctrl_t'(CTRL_RESET); // [R16]
    end else if (dpWrite_reg && dpIdx_reg == CTRL_IDX) begin
      ctrl_reg <= rlwg_ctrl_t'(hwdata[7:0]);
    end else if (hwClear) begin
      ctrl_reg.generatorEnable <= 1'b0; // [R7] [R8]
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      timing_reg <= rlwg_timing_t'(TIMING_RESET); // [R16]
    end else if (dpWrite_reg && dpIdx_reg == TIMING_IDX) begin
      timing_reg <= rlwg_timing_t'(hwdata[7:0]);
    end
  end

  // Transmit buffer, one byte per word
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < BUF_BYTES; i++) begin
        txBuf[i] <= BYTE_RESET;
      end
    end else if (dpWrite_reg && dpIdx_reg >= BUF_BASE_IDX && dpIdx_reg <= BUF_LAST_IDX) begin
      txBuf[5'(dpIdx_reg - BUF_BASE_IDX)] <= hwdata[7:0]; // [R1]
    end
  end

  // Base unit tick; fractional accumulator keeps the long-run rate exact
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      acc_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (acc_reg + ACC_STEP >= ACC_LIMIT) begin
      acc_reg  <= acc_reg + ACC_STEP - ACC_LIMIT;
      tick_reg <= 1'b1;
    end else begin
      acc_reg  <= acc_reg + ACC_STEP;
      tick_reg <= 1'b0;
    end
  end

  // Field decode
  assign frameBytes  = BYTES_PER_LED * (5'(ctrl_reg.frameLengthSelect) + 5'h01); // [R5]
  assign periodUnits = PERIOD_BASE + 5'(timing_reg.bitPeriodSelect); // [R10]
  assign highUnits   = shift_reg[7]
                     ? ONE_HIGH_BASE + 5'(timing_reg.oneHighTimeSelect) // [R3] [R11]
                     : ZERO_HIGH_BASE + 5'(timing_reg.zeroHighTimeSelect); // [R2] [R12]

  always_comb begin
    case (ctrl_reg.resetGapSelect) // [R9]
      2'h0:    gapCode = 16'(GAP_CODE0);
      2'h1:    gapCode = 16'(GAP_CODE1);
      2'h2:    gapCode = 16'(GAP_CODE2);
      default: gapCode = 16'(GAP_CODE3);
    endcase
  end
  assign gapUnits = 16'(gapCode * 16'(GAP_SCALE)); // [R9]

  // Sequencing events
  assign bitEnd     = tick_reg && byteValid_reg && (unitCnt_reg == periodUnits - 5'h01);
  assign lastBitEnd = bitEnd && (bitIdx_reg == 3'h7);
  assign frameEnd   = (state_reg == ST_BITS) && lastBitEnd && (txLeft_reg == '0);
  // Repeating modes end one unit early; the next frame's first byte loads a tick later
  assign gapEnd     = (state_reg == ST_GAP) && tick_reg
                    && (gapCnt_reg + 16'(!ctrl_reg.runModeSelect[1]) == gapUnits - 16'h0001);
  // Next byte loads on the same tick the previous one ends: no idle between bytes
  assign pop = (state_reg == ST_BITS) && tick_reg && fifoOutValid && (txLeft_reg != '0)
             && (!byteValid_reg || lastBitEnd); // [R15]
  assign startFrame = ctrl_reg.generatorEnable
                    && ((state_reg == ST_IDLE) || (gapEnd && !ctrl_reg.runModeSelect[1])); // [R6]
  assign hwClear = ctrl_reg.generatorEnable
                 && ((frameEnd && ctrl_reg.runModeSelect == MODE_ONE_NOGAP) // [R8]
                 || (gapEnd && ctrl_reg.runModeSelect == MODE_ONE_GAP)); // [R7]

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
    end else if (!ctrl_reg.generatorEnable) begin
      state_reg <= ST_IDLE; // [R14]
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_BITS; // [R13]
        end
        ST_BITS: begin
          if (frameEnd) begin
            state_reg <= (ctrl_reg.runModeSelect == MODE_ONE_NOGAP) ? ST_IDLE : ST_GAP; // [R4]
          end
        end
        ST_GAP: begin
          if (gapEnd) begin
            state_reg <= ctrl_reg.runModeSelect[1] ? ST_IDLE : ST_BITS; // [R6] [R7]
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Feeder: buffer bytes in address order into the FIFO
  assign fifoInValid = (state_reg == ST_BITS) && (feedLeft_reg != '0);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      feedIdx_reg  <= '0;
      feedLeft_reg <= '0;
    end else if (startFrame) begin
      feedIdx_reg  <= '0; // [R15]
      feedLeft_reg <= frameBytes; // [R5]
    end else if (fifoInValid && fifoInReady) begin
      feedIdx_reg  <= feedIdx_reg + 5'h01; // [R1]
      feedLeft_reg <= feedLeft_reg - 5'h01;
    end
  end

  // Idle state flushes the FIFO so an aborted frame leaves nothing behind
  rlwg_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rlwg_fifo (
    .mclk     (mclk),
    .nrst     (nrst),
    .flush    (state_reg == ST_IDLE),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (txBuf[feedIdx_reg]),
    .outValid (fifoOutValid),
    .outReady (pop),
    .outData  (fifoOutData)
  );

  // Bytes still to be loaded into the shifter this frame
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      txLeft_reg <= '0;
    end else if (startFrame) begin
      txLeft_reg <= frameBytes;
    end else if (pop) begin
      txLeft_reg <= txLeft_reg - 5'h01;
    end
  end

  // Shifter, most significant bit first
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      shift_reg     <= '0;
      byteValid_reg <= 1'b0;
      bitIdx_reg    <= '0;
    end else if (state_reg != ST_BITS) begin
      byteValid_reg <= 1'b0;
      bitIdx_reg    <= '0;
    end else if (pop) begin
      shift_reg     <= fifoOutData;
      byteValid_reg <= 1'b1;
      bitIdx_reg    <= '0;
    end else if (lastBitEnd) begin
      byteValid_reg <= 1'b0;
    end else if (bitEnd) begin
      shift_reg  <= {shift_reg[6:0], 1'b0}; // [R15]
      bitIdx_reg <= bitIdx_reg + 3'h1;
    end
  end

  // Unit counter inside one bit; restarts when a bit ends or a byte loads
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      unitCnt_reg <= '0;
    end else if (!byteValid_reg || bitEnd || pop) begin
      unitCnt_reg <= '0;
    end else if (tick_reg) begin
      unitCnt_reg <= unitCnt_reg + 5'h01;
    end
  end

  // Reset gap counter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gapCnt_reg <= '0;
    end else if (state_reg != ST_GAP) begin
      gapCnt_reg <= '0;
    end else if (tick_reg) begin
      gapCnt_reg <= gapCnt_reg + 16'h0001; // [R4]
    end
  end

  // Encoded waveform: high for the selected high time, low for the rest
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      waveOut_reg <= 1'b0;
    end else begin
      waveOut_reg <= (state_reg == ST_BITS) && byteValid_reg
                   && (unitCnt_reg < highUnits); // [R2] [R3]
    end
  end

  // Pin ownership: generator while enabled, GPIO otherwise
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pinOut_reg <= 1'b0;
      pinOe_reg  <= 1'b0;
    end else if (ctrl_reg.generatorEnable) begin
      pinOut_reg <= waveOut_reg; // [R13]
      pinOe_reg  <= 1'b1;
    end else begin
      pinOut_reg <= gpioOutValue; // [R13]
      pinOe_reg  <= gpioOutEnable;
    end
  end
  assign ledPinOut = pinOut_reg;
  assign ledPinOe  = pinOe_reg;

  // Pin read-back synchroniser
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pinSync1_reg <= 1'b0;
      pinSync2_reg <= 1'b0;
    end else begin
      pinSync1_reg <= ledPinIn;
      pinSync2_reg <= pinSync1_reg;
    end
  end
  assign gpioInValue = pinSync2_reg;

  // Transfer size is not checked; only whole words are issued on this bus
  logic unusedSize;
  assign unusedSize = ^hsize;

endmodule

// ==== dv/rlwg_monitor.sv ====
// Checker on rlwg_top ports: bus timing, pin hand-over, pulse limits.
// Assumes one AHB-Lite master; shadow enable ignores the one-shot hw clear.
`timescale 1ns/10ps
module rlwg_monitor
  import rlwg_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        ledPinOut,
  input wire logic        ledPinOe,
  input wire logic        gpioOutEnable
);
  logic       addrTaken;
  logic       ctrlWr;
  logic       enShadow;
  logic       outPrev;
  logic [9:0] highRun;
  logic [9:0] riseGap;

  assign addrTaken = hsel && htrans == HTRANS_NONSEQ && hready;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrlWr   <= 1'b0;
      enShadow <= 1'b0;
    end else begin
      ctrlWr <= addrTaken && hwrite && haddr == {CTRL_IDX, 2'b00};
      if (ctrlWr) begin
        enShadow <= hwdata[0];
      end
    end
  end

  // Saturating, so a long idle never wraps into a short count
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      outPrev <= 1'b0;
      highRun <= 10'h000;
      riseGap <= 10'h000;
    end else begin
      outPrev <= ledPinOut;
      highRun <= !ledPinOut ? 10'h000 : highRun + 10'(highRun != 10'h3ff);
      riseGap <= (ledPinOut && !outPrev) ? 10'h001 : riseGap + 10'(riseGap != 10'h3ff);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence pulseEnd;
    enShadow && ledPinOe && $fell(ledPinOut);
  endsequence
  sequence pulseStart;
    enShadow && ledPinOe && $rose(ledPinOut);
  endsequence

  chk_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("hresp not OKAY");
  chk_read_wait: assert property ((addrTaken && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_nowait: assert property ((addrTaken && hwrite) |=> hreadyout)
    else $error("write stalled");
  chk_upper_zero: assert property (hrdata[31:8] == 24'h000000)
    else $error("hrdata upper bits set");
  chk_gpio_follow: assert property ((!enShadow) [*4] |-> ledPinOe == $past(gpioOutEnable))
    else $error("pin not with GPIO");
  chk_gen_drive: assert property ($rose(enShadow) |-> ##[1:4] ledPinOe)
    else $error("generator did not take pin");
  chk_high_min: assert property (pulseEnd |-> highRun >= 10'd8)
    else $error("high pulse too short");
  chk_high_max: assert property (pulseEnd |-> highRun <= 10'd43)
    else $error("high pulse too long");
  chk_period_min: assert property (pulseStart |-> riseGap >= 10'd40)
    else $error("bit period too short");

  cov_read: cover property (addrTaken && !hwrite);
  cov_stop: cover property ($fell(enShadow));
  cov_bit: cover property (pulseEnd);
endmodule

bind rlwg_top rlwg_monitor u_rlwg_monitor (
  .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .ledPinOut(ledPinOut), .ledPinOe(ledPinOe),
  .gpioOutEnable(gpioOutEnable));

// ==== dv/rlwg_led_chain_model.sv ====
// LED chain model: decodes the pulse-width stream on the data wire.
// Assumes pulses span many mclk cycles; long highs (idle pull-up) are no bit.
`timescale 1ns/10ps
module rlwg_led_chain_model #(
  parameter int ONE_THR = 20,
  parameter int GAP_THR = 60
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ledWire,
  output logic      [31:0] bitsSeen,
  output logic      [15:0] frameBits,
  output logic      [15:0] frameCnt,
  output logic      [15:0] hiZero,
  output logic      [15:0] hiOne,
  output logic      [15:0] periodCyc,
  output logic      [15:0] gapLow
);
  logic        wirePrev;
  logic [15:0] hiRun;
  logic [15:0] loRun;
  logic [15:0] riseRun;
  logic [15:0] bitCnt;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {wirePrev, hiRun, loRun, riseRun, bitCnt} <= '0;
      {bitsSeen, frameBits, frameCnt, hiZero, hiOne, periodCyc, gapLow} <= '0;
    end else begin
      wirePrev <= ledWire;
      riseRun  <= (ledWire && !wirePrev) ? 16'h0001 : riseRun + 16'h0001;
      if (ledWire) begin
        hiRun <= hiRun + 16'h0001;
        loRun <= 16'h0000;
        if (!wirePrev && loRun > GAP_THR) gapLow <= loRun;
        if (!wirePrev && loRun <= GAP_THR) periodCyc <= riseRun;
      end else begin
        loRun <= loRun + 16'h0001;
        hiRun <= 16'h0000;
        if (wirePrev && hiRun < GAP_THR) begin
          bitsSeen <= {bitsSeen[30:0], hiRun > ONE_THR};
          bitCnt   <= bitCnt + 16'h0001;
          if (hiRun > ONE_THR) hiOne <= hiRun;
          else hiZero <= hiRun;
        end
        // A low this long can only be a gap or a released line
        if (loRun == GAP_THR && bitCnt != 16'h0000) begin
          frameBits <= bitCnt;
          frameCnt  <= frameCnt + 16'h0001;
          bitCnt    <= 16'h0000;
        end
      end
    end
  end
endmodule

// ==== dv/rlwg_tb_top.sv ====
// Testbench for rlwg_top: AHB-Lite master, pad with pull-up, LED chain model.
// Assumes GAP_SCALE of 8, so a gap outlasts any bit's low time.
`timescale 1ns/10ps
module rlwg_tb_top;
  import rlwg_pkg::*;
  localparam int  GSC  = 8;
  localparam real UCYC = 2.4112;
  logic        mclk, nrst, hsel, hwrite, hreadyout, hresp;
  logic        ledWire, ledPinOut, ledPinOe, gpioOutValue, gpioOutEnable, gpioInValue;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, bitsSeen;
  logic [15:0] frameBits, frameCnt, hiZero, hiOne, periodCyc, gapLow;
  int          errTotal, numChecks;

  assign ledWire = ledPinOe ? ledPinOut : 1'b1; // Pull-up when undriven

  rlwg_top #(.GAP_SCALE(GSC), .FIFO_DEPTH(8)) u_rlwg_top (
    .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ledPinIn(ledWire),
    .ledPinOut(ledPinOut), .ledPinOe(ledPinOe), .gpioOutValue(gpioOutValue),
    .gpioOutEnable(gpioOutEnable), .gpioInValue(gpioInValue));

  rlwg_led_chain_model u_rlwg_led_chain_model (
    .mclk(mclk), .nrst(nrst), .ledWire(ledWire), .bitsSeen(bitsSeen),
    .frameBits(frameBits), .frameCnt(frameCnt), .hiZero(hiZero), .hiOne(hiOne),
    .periodCyc(periodCyc), .gapLow(gapLow));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [7:0] patByte(input int i);
    return 8'(i * 37 + 27);
  endfunction

  task automatic printVerdict();
    if (errTotal == 0 && numChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic checkEq(input logic [31:0] got, input logic [31:0] exp, input string what);
    numChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Base units land on 2 or 3 cycles, so allow a few cycles of slack
  task automatic checkNear(input logic [15:0] got, input real units, input string what);
    int exp;
    exp = int'(units * UCYC);
    numChecks++;
    if ((got inside {[exp - 3:exp + 3]}) !== 1'b1) begin
      errTotal++;
      $display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic ahbXfer(input logic [29:0] idx, input logic wr, input logic [7:0] wd,
                         output logic [31:0] rd);
    @(posedge mclk);
    haddr  <= {idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wrReg(input logic [29:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    ahbXfer(idx, 1'b1, wd, rd);
  endtask

  task automatic rdChk(input logic [29:0] idx, input logic [7:0] exp, input string what);
    logic [31:0] rd;
    ahbXfer(idx, 1'b0, 8'h00, rd);
    checkEq(rd, {24'h000000, exp}, what);
  endtask

  task automatic fillBuf(input int n);
    for (int i = 0; i < n; i++) wrReg(BUF_BASE_IDX + 30'(i), patByte(i));
  endtask

  task automatic waitIdle();
    logic [31:0] rd;
    rd = 32'h1;
    for (int i = 0; i < 5000 && rd[0] !== 1'b0; i++) ahbXfer(CTRL_IDX, 1'b0, 8'h00, rd);
    repeat (100) @(posedge mclk);
  endtask

  task automatic testRegs();
    rdChk(CTRL_IDX, 8'h00, "ctrl reset");
    rdChk(TIMING_IDX, 8'h00, "timing reset");
    wrReg(TIMING_IDX, 8'ha6);
    rdChk(TIMING_IDX, 8'ha6, "timing rw");
    wrReg(30'h00000123, 8'h5a);
    rdChk(30'h00000123, 8'h00, "unmapped");
    wrReg(CTRL_IDX, 8'hfe);
    rdChk(CTRL_IDX, 8'hfe, "ctrl rw");
    wrReg(CTRL_IDX, 8'h00);
    wrReg(TIMING_IDX, 8'h00);
  endtask

  task automatic testGpio();
    @(posedge mclk);
    gpioOutEnable <= 1'b0;
    repeat (4) @(posedge mclk);
    checkEq(32'(ledPinOe), 0, "gpio released");
    checkEq(32'(gpioInValue), 1, "gpio in high");
    gpioOutEnable <= 1'b1;
    repeat (4) @(posedge mclk);
    checkEq(32'(gpioInValue), 0, "gpio in low");
    checkEq(32'(ledPinOe), 1, "gpio drives");
    // Let the chain model close the pull-up blip before frames are counted
    repeat (100) @(posedge mclk);
  endtask

  task automatic testNoGap();
    logic [15:0] cnt;
    cnt = frameCnt;
    fillBuf(3);
    wrReg(CTRL_IDX, 8'h31);
    waitIdle();
    rdChk(CTRL_IDX, 8'h30, "hw clear");
    checkEq(32'(frameCnt - cnt), 1, "frames");
    checkEq(32'(frameBits), 24, "bits");
    checkEq({8'h00, bitsSeen[23:0]}, {8'h00, patByte(0), patByte(1), patByte(2)}, "data");
    checkNear(hiZero, 4.0, "t0h");
    checkNear(hiOne, 10.0, "t1h");
    checkNear(periodCyc, 17.0, "period");
  endtask

  task automatic testGapFrame();
    logic [15:0] cnt;
    cnt = frameCnt;
    fillBuf(24);
    wrReg(TIMING_IDX, 8'hff);
    wrReg(CTRL_IDX, 8'hef);
    waitIdle();
    rdChk(CTRL_IDX, 8'hee, "hw clear gap");
    checkEq(32'(frameCnt - cnt), 1, "frames");
    checkEq(32'(frameBits), 192, "bits");
    checkEq(bitsSeen, {patByte(20), patByte(21), patByte(22), patByte(23)}, "data");
    checkNear(hiZero, 7.0, "t0h");
    checkNear(hiOne, 17.0, "t1h");
    checkNear(periodCyc, 24.0, "period");
    wrReg(TIMING_IDX, 8'h00);
  endtask

  task automatic testContinuous();
    logic [5:0]  gaps [4];
    logic [7:0]  ctrl;
    logic [15:0] cnt;
    real         lowUnits;
    gaps = '{GAP_CODE0, GAP_CODE1, GAP_CODE2, GAP_CODE3};
    ctrl = patByte(2);
    lowUnits = ctrl[0] ? 7.0 : 13.0;
    for (int g = 0; g < 4; g++) begin
      ctrl = {2'(g), 2'(g % 2), 3'h0, 1'b1};
      cnt = frameCnt;
      wrReg(CTRL_IDX, ctrl);
      for (int n = 0; n < 20000 && frameCnt < cnt + 16'h0002; n++) @(posedge mclk);
      checkNear(gapLow, lowUnits + real'(gaps[g]) * GSC, "gap");
      rdChk(CTRL_IDX, ctrl, "stays on");
      @(posedge mclk);
      gpioOutEnable <= 1'b0;
      wrReg(CTRL_IDX, 8'h00);
      repeat (4) @(posedge mclk);
      checkEq(32'(ledPinOe), 0, "stop");
      gpioOutEnable <= 1'b1;
      repeat (100) @(posedge mclk);
    end
  endtask

  initial begin
    {nrst, haddr, htrans, hwrite, hwdata, gpioOutValue} = '0;
    hsel = 1'b1;
    hsize = 3'h2;
    gpioOutEnable = 1'b1;
    errTotal = 0;
    numChecks = 0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    testRegs();
    testGpio();
    testNoGap();
    testGapFrame();
    testContinuous();
    printVerdict();
  end

  // Longest legal run is about 23000 cycles
  initial begin
    repeat (80000) @(posedge mclk);
    errTotal++;
    $display("[FAIL] %0t watchdog expired", $time);
    printVerdict();
  end
endmodule
